/* File: bench/stb_config_regs_checker.sv */
`timescale 1ns/1ps
// ****
// register bank port checks
// ****
module stb_config_regs_checker (
   input wire logic        clk,
   input wire logic        reset_n,
   input wire logic        reg_wr,
   input wire logic        reg_rd,
   input wire logic [6:0]  reg_addr,
   input wire logic [7:0]  reg_wdata,
   input wire logic [7:0]  reg_rdata_q,
   input wire logic [3:0]  unit_gap_count_q,
   input wire logic        tx_user_zero_q,
   input wire logic [9:0]  tx_user_raw_len_q,
   input wire logic        status_copy_en_q,
   input wire logic        tx_status_page_select_q,
   input wire logic        rx_status_page_select_q,
   input wire logic [15:0] message_gap_count_q
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);
   // mode 11 writes are refused, so only legal ones are traced
   wire w0d = reg_wr && reg_addr == 7'h0d && reg_wdata[2:1] != 2'b11;
   wire w0e = reg_wr && reg_addr == 7'h0e;
   wire w10 = reg_wr && reg_addr == 7'h10;
   a_tx_page_map:
   assert property (w0e |-> ##2 tx_status_page_select_q == $past(reg_wdata[1], 2))
      else $error("tx page select wrong");
   a_rx_page_map:
   assert property (w0e |-> ##2 rx_status_page_select_q == $past(reg_wdata[0], 2))
      else $error("rx page select wrong");
   a_copy_off_bit:
   assert property (w0e |-> ##2 status_copy_en_q != $past(reg_wdata[4], 2))
      else $error("copy enable wrong");
   a_zero_mode:
   assert property (w0d |-> ##2 tx_user_zero_q == ($past(reg_wdata[2:1], 2) == 2'b00))
      else $error("zero mode decode wrong");
   a_raw_length:
   assert property (w0d |-> ##2 tx_user_raw_len_q == ($past(reg_wdata[0], 2) ? 10'h300 : 10'h180))
      else $error("raw length wrong");
   a_unit_gap_max:
   assert property (unit_gap_count_q <= 4'h8)
      else $error("unit gap above eight");
   a_msg_gap_low:
   assert property (w10 |-> ##2 message_gap_count_q[7:0] == $past(reg_wdata, 2))
      else $error("message gap low byte wrong");
   a_reserved_read:
   assert property (reg_rd && reg_addr == 7'h0e |=> (reg_rdata_q & 8'hcc) == 8'h00)
      else $error("reserved bits not zero");
   cover property (reg_wr && reg_addr == 7'h0d && reg_wdata[2:1] == 2'b11);
   cover property (w10);
   cover property (reg_rd && reg_addr == 7'h11);
endmodule

bind stb_config_regs stb_config_regs_checker u_chk (
   .clk, .reset_n, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata_q,
   .unit_gap_count_q, .tx_user_zero_q, .tx_user_raw_len_q, .status_copy_en_q,
   .tx_status_page_select_q, .rx_status_page_select_q, .message_gap_count_q
);

/* File: bench/stb_config_regs_tb.sv */
`timescale 1ns/1ps
// ****
// register bank bench
// ****
module stb_config_regs_tb;
   logic        clk, reset_n, reg_wr, reg_rd;
   logic [6:0]  reg_addr;
   logic [7:0]  reg_wdata, reg_rdata_q;
   logic [3:0]  unit_gap_count_q, auto_gap_max_q;
   logic [1:0]  tx_user_buffer_mode_q;
   logic [9:0]  tx_user_raw_len_q;
   logic [15:0] message_gap_count_q;
   logic        tx_user_split_q, tx_user_buffer_size_q, tx_user_zero_q, tx_user_raw_q;
   logic        tx_user_unit_q, status_shared_q, status_copy_en_q, tx_status_page_select_q;
   logic        rx_status_page_select_q, user_passthrough_en_q, status_passthrough_en_q;
   logic        unit_gap_adjust_en_q;
   int          num_errors, check_count;

   stb_config_regs u_dut (
      .clk, .reset_n, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata_q,
      .unit_gap_count_q, .tx_user_split_q, .tx_user_buffer_mode_q, .tx_user_buffer_size_q,
      .tx_user_zero_q, .tx_user_raw_q, .tx_user_unit_q, .tx_user_raw_len_q, .status_shared_q,
      .status_copy_en_q, .tx_status_page_select_q, .rx_status_page_select_q,
      .message_gap_count_q, .user_passthrough_en_q, .status_passthrough_en_q,
      .unit_gap_adjust_en_q, .auto_gap_max_q
   );

   always #5 clk = ~clk;

   task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
      check_count++;
      if (got !== exp) begin
         num_errors++;
         $display("[ERR] %s expected %h seen %h", nm, exp, got);
      end
   endtask

   // one idle cycle after each write so decoded outputs have landed
   task automatic wr(input logic [6:0] a, input logic [7:0] d);
      @(negedge clk);
      reg_wr = 1'b1;
      reg_addr = a;
      reg_wdata = d;
      @(negedge clk);
      reg_wr = 1'b0;
      @(negedge clk);
   endtask

   task automatic rd(input logic [6:0] a, input logic [7:0] exp);
      @(negedge clk);
      reg_rd = 1'b1;
      reg_addr = a;
      @(negedge clk);
      reg_rd = 1'b0;
      chk("reg_rdata_q", exp, reg_rdata_q);
   endtask

   task automatic t_reset();
      rd(7'h0d, 8'h00);
      rd(7'h0e, 8'h00);
      rd(7'h0f, 8'h00);
      rd(7'h10, 8'h09);
      rd(7'h11, 8'h00);
      chk("message_gap_count_q", 16'h0009, message_gap_count_q);
      chk("zero_q", 1'b1, tx_user_zero_q);
      chk("raw_len_q", 10'h180, tx_user_raw_len_q);
      chk("copy_en_q", 1'b1, status_copy_en_q);
   endtask

   task automatic t_user();
      logic [1:0] m;
      for (int i = 0; i < 3; i++) begin
         m = i[1:0];
         wr(7'h0d, {4'h8, 1'b1, m, i[0]});
         chk("mode_q", m, tx_user_buffer_mode_q);
         chk("zero_q", m == 2'b00, tx_user_zero_q);
         chk("raw_q", m == 2'b01, tx_user_raw_q);
         chk("unit_q", m == 2'b10, tx_user_unit_q);
         chk("raw_len_q", i[0] ? 10'h300 : 10'h180, tx_user_raw_len_q);
         chk("size_q", i[0], tx_user_buffer_size_q);
      end
      chk("unit_gap_count_q", 4'h8, unit_gap_count_q);
      chk("split_q", 1'b1, tx_user_split_q);
      wr(7'h0d, 8'h96);
      rd(7'h0d, 8'h8c);
      wr(7'h0d, 8'h30);
      rd(7'h0d, 8'h30);
      chk("split_q", 1'b0, tx_user_split_q);
   endtask

   task automatic t_status();
      wr(7'h0e, 8'hff);
      rd(7'h0e, 8'h33);
      chk("shared_q", 1'b1, status_shared_q);
      chk("copy_en_q", 1'b0, status_copy_en_q);
      chk("tx_page_q", 1'b1, tx_status_page_select_q);
      chk("rx_page_q", 1'b1, rx_status_page_select_q);
      wr(7'h0e, 8'h02);
      chk("shared_q", 1'b0, status_shared_q);
      chk("copy_en_q", 1'b1, status_copy_en_q);
      chk("rx_page_q", 1'b0, rx_status_page_select_q);
   endtask

   task automatic t_gap_pass();
      wr(7'h0f, 8'ha5);
      wr(7'h10, 8'h3c);
      chk("message_gap_count_q", 16'ha53c, message_gap_count_q);
      wr(7'h11, 8'hff);
      rd(7'h11, 8'h70);
      chk("user_pass_q", 1'b1, user_passthrough_en_q);
      chk("status_pass_q", 1'b1, status_passthrough_en_q);
      chk("adjust_q", 1'b1, unit_gap_adjust_en_q);
      wr(7'h11, 8'h48);
      chk("adjust_q", 1'b0, unit_gap_adjust_en_q);
      chk("auto_gap_q", 4'h8, auto_gap_max_q);
      chk("status_pass_q", 1'b0, status_passthrough_en_q);
      wr(7'h12, 8'hff);
      rd(7'h12, 8'h00);
   endtask

   task automatic tally_and_finish();
      $display("errors %0d checks %0d", num_errors, check_count);
      if (num_errors == 0 && check_count > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   initial begin
      clk = 1'b0;
      reset_n = 1'b0;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = 7'h00;
      reg_wdata = 8'h00;
      repeat (20) @(negedge clk);
      reset_n = 1'b1;
      t_reset();
      t_user();
      t_status();
      t_gap_pass();
      reset_n = 1'b0;
      repeat (2) @(negedge clk);
      reset_n = 1'b1;
      t_reset();
      tally_and_finish();
   end

   // about 90 cycles expected, so 5000 means a hang
   initial begin
      #50000;
      num_errors++;
      tally_and_finish();
   end
endmodule

/* File: src/stb_config_regs.sv */
`timescale 1ns/1ps

// Overview of operation
// (R1) zero bits between units set 0..8
// (R2) bit 3 shares or splits user buffers
// (R3) mode 00 sends zero user bits
// (R4) mode 01 uses raw fixed-length buffer
// (R5) mode 10 sends consumer information-unit structure
// (R6) raw size 384 or 768, Z start
// (R7) shared status copies A into B
// (R8) copy-disable stops status copy to serializer
// (R9) tx status page A/B at 0x38-0x4f
// (R10) rx status page A/B at 0x20-0x37
// (R11) message gap high byte resets 0x00
// (R12) message gap low byte resets 0x09
// (R13) user passthrough enable from receiver
// (R14) status passthrough enable from receiver
// (R15) autobuffer gap adjust up to 0..8
// (R16) reserved bits read zero, illegal codes ignored
module stb_config_regs
   import stb_pkg::*;
(
   input  wire logic       clk,
   input  wire logic       reset_n,
   input  wire logic       reg_wr,
   input  wire logic       reg_rd,
   input  wire logic [6:0] reg_addr,
   input  wire logic [7:0] reg_wdata,
   output logic      [7:0] reg_rdata_q,
   output logic      [3:0] unit_gap_count_q,
   output logic            tx_user_split_q,
   output logic      [1:0] tx_user_buffer_mode_q,
   output logic            tx_user_buffer_size_q,
   output logic            tx_user_zero_q,
   output logic            tx_user_raw_q,
   output logic            tx_user_unit_q,
   output logic      [9:0] tx_user_raw_len_q,
   output logic            status_shared_q,
   output logic            status_copy_en_q,
   output logic            tx_status_page_select_q,
   output logic            rx_status_page_select_q,
   output logic     [15:0] message_gap_count_q,
   output logic            user_passthrough_en_q,
   output logic            status_passthrough_en_q,
   output logic            unit_gap_adjust_en_q,
   output logic      [3:0] auto_gap_max_q
);

   // ****************************************
   // register storage
   // ****************************************
   logic [7:0] page_select_q;
   logic [7:0] gap_high_q;
   logic [7:0] gap_low_q;
   logic [7:0] passthrough_q;
   logic [3:0] unit_gap_q;
   logic [2:0] user_cfg_q;
   logic [3:0] auto_gap_q;
   logic       wr_setup;
   logic       wr_pass;
   logic [1:0] wmode;
   logic [7:0] rdata_d;

   assign wr_setup = reg_wr && (reg_addr == TX_USER_BUFFER_SETUP_ADDR);
   assign wr_pass  = reg_wr && (reg_addr == PASSTHROUGH_CONTROL_ADDR);
   assign wmode    = reg_wdata[TX_USER_MODE_LSB +: 2];

   // ****************************************
   // encoded fields, illegal codes keep old value
   // ****************************************
   // field with encoding above 8 is not taken
   stb_field_hold #(.WIDTH(4), .RST(TX_USER_BUFFER_SETUP_RST[7:4])) u_unit_gap (
      .clk     (clk),
      .reset_n (reset_n),
      .load    (wr_setup),
      .legal   (reg_wdata[UNIT_GAP_LSB +: 4] <= UNIT_GAP_MAX),
      .value   (reg_wdata[UNIT_GAP_LSB +: 4]),
      .held_q  (unit_gap_q)
   ); // R1 R16

   // reserved mode 11 is not taken; split bit and size move with mode
   stb_field_hold #(.WIDTH(3), .RST(TX_USER_BUFFER_SETUP_RST[3:1])) u_user_cfg (
      .clk     (clk),
      .reset_n (reset_n),
      .load    (wr_setup),
      .legal   (wmode != STB_MODE_RSVD),
      .value   (reg_wdata[3:1]),
      .held_q  (user_cfg_q)
   ); // R3 R16

   logic user_size_q;
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         user_size_q <= TX_USER_BUFFER_SETUP_RST[TX_USER_SIZE_BIT];
      end else if (wr_setup && wmode != STB_MODE_RSVD) begin
         user_size_q <= reg_wdata[TX_USER_SIZE_BIT];
      end
   end

   stb_field_hold #(.WIDTH(4), .RST(PASSTHROUGH_CONTROL_RST[3:0])) u_auto_gap (
      .clk     (clk),
      .reset_n (reset_n),
      .load    (wr_pass),
      .legal   (reg_wdata[AUTO_GAP_LSB +: 4] <= UNIT_GAP_MAX),
      .value   (reg_wdata[AUTO_GAP_LSB +: 4]),
      .held_q  (auto_gap_q)
   ); // R15 R16

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         page_select_q <= STATUS_BUFFER_PAGE_SELECT_RST;
      end else if (reg_wr && reg_addr == STATUS_BUFFER_PAGE_SELECT_ADDR) begin
         page_select_q <= reg_wdata & PAGE_SELECT_MASK; // R16
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         gap_high_q <= MESSAGE_GAP_COUNT_HIGH_RST; // R11
      end else if (reg_wr && reg_addr == MESSAGE_GAP_COUNT_HIGH_ADDR) begin
         gap_high_q <= reg_wdata;
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         gap_low_q <= MESSAGE_GAP_COUNT_LOW_RST; // R12
      end else if (reg_wr && reg_addr == MESSAGE_GAP_COUNT_LOW_ADDR) begin
         gap_low_q <= reg_wdata;
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         passthrough_q <= PASSTHROUGH_CONTROL_RST;
      end else if (wr_pass) begin
         passthrough_q <= reg_wdata & PASSTHROUGH_MASK; // R16
      end
   end

   // ****************************************
   // read path, registered, one cycle after reg_rd
   // ****************************************
   always_comb begin
      // reserved bits are masked at write time; unmapped reads give zero
      case (reg_addr)
         TX_USER_BUFFER_SETUP_ADDR:      rdata_d = {unit_gap_q, user_cfg_q, user_size_q};
         STATUS_BUFFER_PAGE_SELECT_ADDR: rdata_d = page_select_q;
         MESSAGE_GAP_COUNT_HIGH_ADDR:    rdata_d = gap_high_q;
         MESSAGE_GAP_COUNT_LOW_ADDR:     rdata_d = gap_low_q;
         PASSTHROUGH_CONTROL_ADDR:       rdata_d = {passthrough_q[7:4], auto_gap_q};
         default:                        rdata_d = 8'h00;
      endcase
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         reg_rdata_q <= 8'h00;
      end else if (reg_rd) begin
         reg_rdata_q <= rdata_d;
      end
   end

   // ****************************************
   // decoded controls to transmitter, all registered
   // ****************************************
   // extra stage costs a cycle but keeps every output straight from a flop
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         unit_gap_count_q      <= 4'h0;
         tx_user_split_q       <= 1'b0;
         tx_user_buffer_mode_q <= 2'h0;
         tx_user_buffer_size_q <= 1'b0;
         tx_user_zero_q        <= 1'b1;
         tx_user_raw_q         <= 1'b0;
         tx_user_unit_q        <= 1'b0;
         tx_user_raw_len_q     <= RAW_LEN_SHORT;
      end else begin
         unit_gap_count_q      <= unit_gap_q; // R1
         tx_user_split_q       <= user_cfg_q[TX_USER_SPLIT_BIT-1]; // R2
         tx_user_buffer_mode_q <= user_cfg_q[1:0];
         tx_user_buffer_size_q <= user_size_q;
         tx_user_zero_q        <= (user_cfg_q[1:0] == STB_MODE_ZERO); // R3
         tx_user_raw_q         <= (user_cfg_q[1:0] == STB_MODE_RAW); // R4
         tx_user_unit_q        <= (user_cfg_q[1:0] == STB_MODE_UNIT); // R5
         tx_user_raw_len_q     <= user_size_q ? RAW_LEN_LONG : RAW_LEN_SHORT; // R6
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         status_shared_q         <= 1'b0;
         status_copy_en_q        <= !STATUS_BUFFER_PAGE_SELECT_RST[STATUS_COPY_OFF_BIT];
         tx_status_page_select_q <= 1'b0;
         rx_status_page_select_q <= 1'b0;
         // nine zeros between messages until software says otherwise
         message_gap_count_q     <= {MESSAGE_GAP_COUNT_HIGH_RST, MESSAGE_GAP_COUNT_LOW_RST};
      end else begin
         status_shared_q         <= page_select_q[STATUS_SHARED_BIT]; // R7
         status_copy_en_q        <= !page_select_q[STATUS_COPY_OFF_BIT]; // R8
         tx_status_page_select_q <= page_select_q[TX_STATUS_PAGE_BIT]; // R9
         rx_status_page_select_q <= page_select_q[RX_STATUS_PAGE_BIT]; // R10
         message_gap_count_q     <= {gap_high_q, gap_low_q}; // R11 R12
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         user_passthrough_en_q   <= 1'b0;
         status_passthrough_en_q <= 1'b0;
         unit_gap_adjust_en_q    <= 1'b0;
         auto_gap_max_q          <= 4'h0;
      end else begin
         user_passthrough_en_q   <= passthrough_q[USER_PASSTHROUGH_BIT]; // R13
         status_passthrough_en_q <= passthrough_q[STATUS_PASSTHROUGH_BIT]; // R14
         // gap adjust only means something while user bits pass through
         unit_gap_adjust_en_q    <= passthrough_q[UNIT_GAP_ADJUST_BIT]
                                    && passthrough_q[USER_PASSTHROUGH_BIT]; // R15
         auto_gap_max_q          <= auto_gap_q; // R15
      end
   end

endmodule

/* File: src/stb_field_hold.sv */
`timescale 1ns/1ps

// holds a legal copy of a field: illegal codes keep the last legal value
module stb_field_hold
   import stb_pkg::*;
#(
   parameter int          WIDTH     = 4,
   parameter logic [WIDTH-1:0] RST  = '0
) (
   input  wire logic             clk,
   input  wire logic             reset_n,
   input  wire logic             load,
   input  wire logic             legal,
   input  wire logic [WIDTH-1:0] value,
   output logic      [WIDTH-1:0] held_q
);

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         held_q <= RST;
      end else if (load && legal) begin
         held_q <= value;
      end
   end

endmodule

/* File: src/stb_pkg.sv */
package stb_pkg;

   // ****************************************
   // register offsets
   // ****************************************
   localparam logic [6:0] TX_USER_BUFFER_SETUP_ADDR      = 7'h0d;
   localparam logic [6:0] STATUS_BUFFER_PAGE_SELECT_ADDR = 7'h0e;
   localparam logic [6:0] MESSAGE_GAP_COUNT_HIGH_ADDR    = 7'h0f;
   localparam logic [6:0] MESSAGE_GAP_COUNT_LOW_ADDR     = 7'h10;
   localparam logic [6:0] PASSTHROUGH_CONTROL_ADDR       = 7'h11;

   // ****************************************
   // reset values
   // ****************************************
   localparam logic [7:0] TX_USER_BUFFER_SETUP_RST      = 8'h00;
   localparam logic [7:0] STATUS_BUFFER_PAGE_SELECT_RST = 8'h00;
   localparam logic [7:0] MESSAGE_GAP_COUNT_HIGH_RST    = 8'h00;
   localparam logic [7:0] MESSAGE_GAP_COUNT_LOW_RST     = 8'h09;
   localparam logic [7:0] PASSTHROUGH_CONTROL_RST       = 8'h00;

   // ****************************************
   // writable bit masks, reserved bits stay zero
   // ****************************************
   localparam logic [7:0] PAGE_SELECT_MASK = 8'h33;
   localparam logic [7:0] PASSTHROUGH_MASK = 8'h7f;

   // ****************************************
   // field positions
   // ****************************************
   localparam int UNIT_GAP_LSB          = 4;
   localparam int TX_USER_SPLIT_BIT     = 3;
   localparam int TX_USER_MODE_LSB      = 1;
   localparam int TX_USER_SIZE_BIT      = 0;
   localparam int STATUS_SHARED_BIT     = 5;
   localparam int STATUS_COPY_OFF_BIT   = 4;
   localparam int TX_STATUS_PAGE_BIT    = 1;
   localparam int RX_STATUS_PAGE_BIT    = 0;
   localparam int UNIT_GAP_ADJUST_BIT   = 6;
   localparam int USER_PASSTHROUGH_BIT  = 5;
   localparam int STATUS_PASSTHROUGH_BIT = 4;
   localparam int AUTO_GAP_LSB          = 0;

   // ****************************************
   // limits and encodings
   // ****************************************
   localparam logic [3:0] UNIT_GAP_MAX  = 4'h8;
   localparam logic [9:0] RAW_LEN_SHORT = 10'h180;
   localparam logic [9:0] RAW_LEN_LONG  = 10'h300;

   typedef enum logic [1:0] {
      STB_MODE_ZERO,
      STB_MODE_RAW,
      STB_MODE_UNIT,
      STB_MODE_RSVD
   } stb_mode_type;

endpackage
